//--- inc/ccc_pkg.sv
// Shared constants for the configuration command control block.
// Assumes 16-bit configuration words and 6-bit register addresses.
package ccc_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 6;
  typedef logic [ADDR_W-1:0] ccc_addr_t;
  typedef logic [WORD_W-1:0] ccc_word_t;
  typedef logic [4:0] ccc_op_t;
  typedef logic [1:0] ccc_sec_t;

  localparam ccc_addr_t ADDR_CHECK = 6'h00;
  localparam ccc_addr_t ADDR_PTR_MAJ = 6'h01;
  localparam ccc_addr_t ADDR_PTR_MIN = 6'h02;
  localparam ccc_addr_t ADDR_FRAME_WR = 6'h03;
  localparam ccc_addr_t ADDR_FRAME_RD = 6'h04;
  localparam ccc_addr_t ADDR_CMD = 6'h05;
  localparam ccc_addr_t ADDR_CTL = 6'h06;
  localparam ccc_addr_t ADDR_QUAL = 6'h07;
  localparam ccc_addr_t ADDR_SER_OUT = 6'h09;
  localparam ccc_addr_t ADDR_PART_ID = 6'h0E;
  localparam ccc_addr_t ADDR_CHAIN_SEL = 6'h12;
  localparam ccc_addr_t ADDR_GEN_ADDR = 6'h13;
  localparam ccc_addr_t ADDR_INIT_VEC = 6'h22;

  localparam ccc_op_t OP_NULL = 5'h00;
  localparam ccc_op_t OP_WRITE_FRAMES = 5'h01;
  localparam ccc_op_t OP_MULTI_FRAME = 5'h02;
  localparam ccc_op_t OP_FINAL_FRAME = 5'h03;
  localparam ccc_op_t OP_READ_FRAMES = 5'h04;
  localparam ccc_op_t OP_START = 5'h05;
  localparam ccc_op_t OP_CHECK_CLEAR = 5'h07;
  localparam ccc_op_t OP_ISOLATE_ROUTING = 5'h08;
  localparam ccc_op_t OP_FLOP_RESTORE = 5'h0A;
  localparam ccc_op_t OP_SHUTDOWN = 5'h0B;
  localparam ccc_op_t OP_DROP_ALIGNMENT = 5'h0D;
  localparam ccc_op_t OP_WARM_REBOOT = 5'h0E;

  localparam int unsigned CTL_CIPHER_BIT = 6;
  localparam int unsigned CTL_SEC_HI = 5;
  localparam int unsigned CTL_SEC_LO = 4;
  localparam int unsigned CTL_KEEP_BIT = 3;
  localparam int unsigned CTL_FUSE_BIT = 2;
  localparam int unsigned CTL_REPORT_BIT = 1;
  localparam ccc_word_t CTL_RESET = 16'h0001;
  localparam ccc_word_t QUAL_RESET = 16'h0000;

  localparam ccc_sec_t SEC_OPEN = 2'h0;
  localparam ccc_sec_t SEC_INTERNAL = 2'h1;
  localparam ccc_sec_t SEC_NOREAD = 2'h2;
  localparam ccc_sec_t SEC_LOCKED = 2'h3;

  typedef enum logic {SER_IDLE, SER_SHIFT} ccc_ser_state_t;
endpackage

//--- inc/ccc_stream_if.sv
// Valid/ready word stream between the block's own modules.
// Assumes both ends share one clock.
interface ccc_stream_if #(parameter int unsigned W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

//--- rtl/ccc_fifo2.sv
// Small word buffer with valid/ready on both sides.
// Assumes one clock; ready is registered so it may feed outputs.
module ccc_fifo2 #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  ccc_stream_if.snk fill,
  ccc_stream_if.src drain
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_ff, rp_ff;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic rdy_ff, push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : p + PW'(1);
  endfunction

  assign push = fill.valid && rdy_ff;
  assign pop = drain.valid && drain.ready;
  assign fill.ready = rdy_ff;
  assign drain.valid = (cnt_ff != '0);
  assign drain.data = mem[rp_ff];
  assign nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else begin
      if (push) wp_ff <= bump(wp_ff);
      if (pop) rp_ff <= bump(rp_ff);
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != FULL);
    end
  end

  // Storage carries no reset; valid alone qualifies it
  always_ff @(posedge clk) begin
    if (push) mem[wp_ff] <= fill.data;
  end
endmodule

//--- rtl/ccc_serializer.sv
// Turns buffered words into a bit stream, most significant bit first.
// Assumes the buffer before it holds words while a shift is running.
module ccc_serializer
  import ccc_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic rst,
  ccc_stream_if.snk words,
  output logic bitOut,
  output logic bitValid
);
  localparam int unsigned BW = $clog2(W);
  localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);
  ccc_ser_state_t state_ff;
  logic [W-1:0] shift_ff;
  logic [BW-1:0] bitCnt_ff;
  logic bitOut_ff, bitValid_ff, load;

  // Taking a word only when idle is what lets the buffer fill up
  assign words.ready = (state_ff == SER_IDLE);
  assign load = words.valid && words.ready;
  assign bitOut = bitOut_ff;
  assign bitValid = bitValid_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SER_IDLE;
      shift_ff <= '0;
      bitCnt_ff <= '0;
      bitOut_ff <= 1'b0;
      bitValid_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        SER_IDLE: begin
          bitValid_ff <= 1'b0;
          if (load) begin
            shift_ff <= {words.data[W-2:0], 1'b0};
            bitOut_ff <= words.data[W-1];
            bitValid_ff <= 1'b1;
            bitCnt_ff <= '0;
            state_ff <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (bitCnt_ff == LAST_BIT - BW'(1)) state_ff <= SER_IDLE;
          bitOut_ff <= shift_ff[W-1];
          shift_ff <= {shift_ff[W-2:0], 1'b0};
          bitCnt_ff <= bitCnt_ff + BW'(1);
        end
      endcase
    end
  end

  property p_ser_first;
    @(posedge clk) disable iff (rst)
      load |=> bitValid_ff && (bitOut_ff == $past(words.data[W-1]));
  endproperty
  a_ser_first: assert property (p_ser_first)
    else $error("first serial bit is not the word's top bit");
endmodule

//--- rtl/ccc_cfg_ctrl.sv
// Configuration command control: register writes, commands, control bits.
// Assumes a packet parser on mclk presents one decoded word per strobe.
module ccc_cfg_ctrl
  import ccc_pkg::*;
#(
  parameter logic [31:0] PART_ID = 32'h1234_5678, // Arbitrary value
  parameter int unsigned IV_W = 128
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wrStb,
  input wire ccc_addr_t wrAddr,
  input wire ccc_word_t wrData,
  output logic wrReady,
  input wire logic rdStb,
  input wire ccc_addr_t rdAddr,
  input wire logic viaInternalPort,
  output ccc_word_t rdData,
  output logic rdValid,
  input wire logic syncFound,
  input wire logic softRebootIn,
  input wire logic [31:0] chkRunning,
  input wire ccc_word_t frameRdData,
  input wire logic internalPortReq,
  output logic frameWrStb,
  output ccc_word_t frameWrData,
  output logic frameRdReq,
  output logic [31:0] framePtr,
  output logic multiFramePulse,
  output logic routingIsolateN,
  output logic startupPulse,
  output logic chkClearPulse,
  output logic flopRestorePulse,
  output logic shutdownPulse,
  output logic deviceOff,
  output logic wordAligned,
  output logic rebootPulse,
  output ccc_word_t rebootAddr,
  output logic cipherOn,
  output ccc_sec_t securityLevel,
  output logic keepLink,
  output logic fuseKeySelect,
  output logic internalPortEn,
  output logic initErrLow,
  output logic idError,
  output logic chainSelN,
  output logic chainData,
  output logic chainDataValid,
  output logic [IV_W-1:0] initVector
);
  ccc_word_t ctl_ff, qual_ff, maj_ff, min_ff, gen_ff, rdData_ff;
  ccc_word_t chainCnt_ff, frameWrData_ff, idHi_ff, chkHi_ff;
  ccc_op_t cmd_ff;
  logic [IV_W-1:0] iv_ff;
  logic rdValid_ff, frameWrStb_ff, frameRdReq_ff, multi_ff, isoN_ff;
  logic start_ff, chkClr_ff, restore_ff, shut_ff, off_ff, aligned_ff;
  logic reboot_ff, portEn_ff, initErr_ff, idErr_ff, chainSelN_ff;
  logic wrDir_ff, rdDir_ff, idOk_ff, idPhase_ff, rdPhase_ff, chkPhase_ff;
  logic startArm_ff, okSeen_ff, dropSeen_ff, shutArm_ff, chkErr_ff;
  logic firstCfg_ff;
  logic take, discard, blocked, accept, exec, chkDone, chkMatch, softBoot;
  logic readOk;
  ccc_sec_t lvl;

  ccc_stream_if #(.W(WORD_W)) serIn ();
  ccc_stream_if #(.W(WORD_W)) serOut ();

  // Level one or more whenever the cipher bit is on
  function automatic ccc_sec_t secForce(input ccc_sec_t l, input logic c);
    return (c && l == SEC_OPEN) ? SEC_INTERNAL : l;
  endfunction

  function automatic ccc_word_t ctlMerge(input ccc_word_t old,
                                         input ccc_word_t wd,
                                         input ccc_word_t q);
    ccc_word_t n;
    n = (old & ~q) | (wd & q);
    if (old[CTL_CIPHER_BIT]) n[CTL_CIPHER_BIT] = 1'b1;
    if (old[CTL_SEC_HI:CTL_SEC_LO] != SEC_OPEN) begin
      n[CTL_SEC_HI:CTL_SEC_LO] = old[CTL_SEC_HI:CTL_SEC_LO];
    end
    n[CTL_SEC_HI:CTL_SEC_LO] = secForce(n[CTL_SEC_HI:CTL_SEC_LO],
                                        n[CTL_CIPHER_BIT]);
    return n;
  endfunction

  function automatic logic isOp(input ccc_op_t op);
    return exec && cmd_ff == op;
  endfunction

  assign lvl = ctl_ff[CTL_SEC_HI:CTL_SEC_LO];
  // Stalling on a full chain buffer holds every write, keeping order
  assign take = wrStb && serIn.ready && aligned_ff;
  assign discard = take && chainCnt_ff != '0;
  // At the top level only the check and command registers stay writable
  assign blocked = lvl == SEC_LOCKED && wrAddr != ADDR_CHECK &&
                   wrAddr != ADDR_CMD;
  assign accept = take && !discard && !blocked;
  assign exec = accept && (wrAddr == ADDR_PTR_MAJ ||
                           wrAddr == ADDR_PTR_MIN);
  assign chkDone = accept && wrAddr == ADDR_CHECK && chkPhase_ff;
  assign chkMatch = chkDone && {chkHi_ff, wrData} == chkRunning;
  assign softBoot = softRebootIn || isOp(OP_WARM_REBOOT);
  assign readOk = rdDir_ff && (lvl == SEC_OPEN ||
                  (lvl == SEC_INTERNAL && viaInternalPort));

  assign serIn.valid = accept && wrAddr == ADDR_SER_OUT;
  assign serIn.data = wrData;

  ccc_fifo2 #(.W(WORD_W), .DEPTH(2)) u_buf (
    .clk(mclk),
    .rst(sys_rst),
    .fill(serIn),
    .drain(serOut)
  );

  ccc_serializer #(.W(WORD_W)) u_ser (
    .clk(mclk),
    .rst(sys_rst),
    .words(serOut),
    .bitOut(chainData),
    .bitValid(chainDataValid)
  );

  // Register writes and stored values
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_ff <= CTL_RESET;
      qual_ff <= QUAL_RESET;
      cmd_ff <= OP_NULL;
      maj_ff <= '0;
      min_ff <= '0;
      gen_ff <= '0;
      iv_ff <= '0;
      idHi_ff <= '0;
      chkHi_ff <= '0;
      idPhase_ff <= 1'b0;
      chkPhase_ff <= 1'b0;
    end else begin
      // The pointer load that runs a warm reboot must still land
      if (accept) begin
        unique case (wrAddr)
          ADDR_CTL: ctl_ff <= ctlMerge(ctl_ff, wrData, qual_ff);
          ADDR_QUAL: qual_ff <= wrData;
          ADDR_CMD: cmd_ff <= wrData[4:0];
          ADDR_PTR_MAJ: maj_ff <= wrData;
          ADDR_PTR_MIN: min_ff <= wrData;
          ADDR_GEN_ADDR: gen_ff <= wrData;
          ADDR_INIT_VEC: iv_ff <= {iv_ff[IV_W-WORD_W-1:0], wrData};
          ADDR_PART_ID: begin
            idHi_ff <= wrData;
            idPhase_ff <= !idPhase_ff;
          end
          ADDR_CHECK: begin
            chkHi_ff <= wrData;
            chkPhase_ff <= !chkPhase_ff;
          end
          default: ;
        endcase
      end
      // Comes last so a soft reboot beats a control write in the same cycle
      if (softBoot) begin
        ctl_ff[CTL_SEC_HI:CTL_SEC_LO] <=
          secForce(SEC_OPEN, ctl_ff[CTL_CIPHER_BIT]);
        qual_ff <= QUAL_RESET;
      end
    end
  end

  // Part id check and frame data path
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      idOk_ff <= 1'b0;
      idErr_ff <= 1'b0;
      frameWrStb_ff <= 1'b0;
      frameWrData_ff <= '0;
    end else begin
      frameWrStb_ff <= 1'b0;
      if (accept && wrAddr == ADDR_PART_ID && idPhase_ff) begin
        idOk_ff <= {idHi_ff, wrData} == PART_ID;
      end
      if (accept && wrAddr == ADDR_FRAME_WR) begin
        if (idOk_ff && wrDir_ff) begin
          frameWrStb_ff <= 1'b1;
          frameWrData_ff <= wrData;
        end else if (!idOk_ff) begin
          idErr_ff <= 1'b1;
        end
      end
    end
  end

  // Chain select countdown; a nested select is discarded and just lowers the count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chainCnt_ff <= '0;
      chainSelN_ff <= 1'b1;
    end else begin
      if (discard) begin
        chainCnt_ff <= chainCnt_ff - WORD_W'(1);
        if (chainCnt_ff == WORD_W'(1)) chainSelN_ff <= 1'b1;
      end else if (accept && wrAddr == ADDR_CHAIN_SEL) begin
        chainCnt_ff <= wrData;
        chainSelN_ff <= (wrData == '0);
      end
    end
  end

  // Command execution; unlisted codes fall through untouched
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrDir_ff <= 1'b0;
      rdDir_ff <= 1'b0;
      isoN_ff <= 1'b1;
      multi_ff <= 1'b0;
      chkClr_ff <= 1'b0;
      restore_ff <= 1'b0;
      reboot_ff <= 1'b0;
    end else begin
      multi_ff <= isOp(OP_MULTI_FRAME);
      chkClr_ff <= isOp(OP_CHECK_CLEAR);
      restore_ff <= isOp(OP_FLOP_RESTORE);
      reboot_ff <= isOp(OP_WARM_REBOOT);
      if (isOp(OP_WRITE_FRAMES)) begin
        wrDir_ff <= 1'b1;
        rdDir_ff <= 1'b0;
      end
      if (isOp(OP_READ_FRAMES)) begin
        rdDir_ff <= 1'b1;
        wrDir_ff <= 1'b0;
      end
      if (isOp(OP_ISOLATE_ROUTING)) isoN_ff <= 1'b0;
      if (isOp(OP_FINAL_FRAME)) isoN_ff <= 1'b1;
    end
  end

  // Alignment, startup and shutdown sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aligned_ff <= 1'b0;
      startArm_ff <= 1'b0;
      okSeen_ff <= 1'b0;
      dropSeen_ff <= 1'b0;
      start_ff <= 1'b0;
      shutArm_ff <= 1'b0;
      shut_ff <= 1'b0;
      off_ff <= 1'b0;
      chkErr_ff <= 1'b0;
      firstCfg_ff <= 1'b1;
    end else begin
      start_ff <= 1'b0;
      shut_ff <= 1'b0;
      // A resync in the same cycle as a drop wins
      if (syncFound) aligned_ff <= 1'b1;
      else if (isOp(OP_DROP_ALIGNMENT)) aligned_ff <= 1'b0;
      if (chkDone) chkErr_ff <= !chkMatch;
      if (isOp(OP_START)) begin
        startArm_ff <= 1'b1;
        okSeen_ff <= 1'b0;
        dropSeen_ff <= 1'b0;
      end else if (startArm_ff) begin
        if (chkMatch) okSeen_ff <= 1'b1;
        if (isOp(OP_DROP_ALIGNMENT)) dropSeen_ff <= 1'b1;
        if (okSeen_ff && dropSeen_ff) begin
          start_ff <= 1'b1;
          startArm_ff <= 1'b0;
          firstCfg_ff <= 1'b0;
        end
      end
      if (isOp(OP_SHUTDOWN)) shutArm_ff <= 1'b1;
      else if (shutArm_ff && (chkMatch || isOp(OP_CHECK_CLEAR))) begin
        shut_ff <= 1'b1;
        off_ff <= 1'b1;
        shutArm_ff <= 1'b0;
      end
    end
  end

  // Reads and control-derived outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_ff <= '0;
      rdValid_ff <= 1'b0;
      rdPhase_ff <= 1'b0;
      frameRdReq_ff <= 1'b0;
      portEn_ff <= 1'b0;
      initErr_ff <= 1'b0;
    end else begin
      rdValid_ff <= rdStb;
      frameRdReq_ff <= rdStb && rdAddr == ADDR_FRAME_RD && readOk;
      if (rdStb && rdAddr == ADDR_PART_ID) rdPhase_ff <= !rdPhase_ff;
      if (rdStb) begin
        unique case (rdAddr)
          ADDR_CMD: rdData_ff <= {11'h000, cmd_ff};
          ADDR_CTL: rdData_ff <= ctl_ff;
          ADDR_QUAL: rdData_ff <= qual_ff;
          ADDR_PART_ID:
            rdData_ff <= rdPhase_ff ? PART_ID[15:0] : PART_ID[31:16];
          ADDR_FRAME_RD: rdData_ff <= readOk ? frameRdData : '0;
          default: rdData_ff <= '0;
        endcase
      end
      portEn_ff <= internalPortReq && !ctl_ff[CTL_KEEP_BIT];
      initErr_ff <= chkErr_ff && (firstCfg_ff ||
                                  !ctl_ff[CTL_REPORT_BIT]);
    end
  end

  assign wrReady = serIn.ready;
  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;
  assign frameWrStb = frameWrStb_ff;
  assign frameWrData = frameWrData_ff;
  assign frameRdReq = frameRdReq_ff;
  assign framePtr = {maj_ff, min_ff};
  assign multiFramePulse = multi_ff;
  assign routingIsolateN = isoN_ff;
  assign startupPulse = start_ff;
  assign chkClearPulse = chkClr_ff;
  assign flopRestorePulse = restore_ff;
  assign shutdownPulse = shut_ff;
  assign deviceOff = off_ff;
  assign wordAligned = aligned_ff;
  assign rebootPulse = reboot_ff;
  assign rebootAddr = gen_ff;
  assign cipherOn = ctl_ff[CTL_CIPHER_BIT];
  assign securityLevel = lvl;
  assign keepLink = ctl_ff[CTL_KEEP_BIT];
  assign fuseKeySelect = ctl_ff[CTL_FUSE_BIT];
  assign internalPortEn = portEn_ff;
  assign initErrLow = initErr_ff;
  assign idError = idErr_ff;
  assign chainSelN = chainSelN_ff;
  assign initVector = iv_ff;

  property p_wr_dir;
    @(posedge mclk) disable iff (sys_rst)
      isOp(OP_WRITE_FRAMES) |=> wrDir_ff && !rdDir_ff;
  endproperty
  a_wr_dir: assert property (p_wr_dir)
    else $error("write-frames code did not open write direction");

  property p_id_gate;
    @(posedge mclk) disable iff (sys_rst)
      accept && wrAddr == ADDR_FRAME_WR && !idOk_ff |=>
        !frameWrStb_ff && idErr_ff;
  endproperty
  a_id_gate: assert property (p_id_gate)
    else $error("frame write passed without part id match");

  property p_chain_sel;
    @(posedge mclk) disable iff (sys_rst)
      accept && wrAddr == ADDR_CHAIN_SEL && wrData == WORD_W'(2) |=>
        !chainSelN && (chainCnt_ff == WORD_W'(2));
  endproperty
  a_chain_sel: assert property (p_chain_sel)
    else $error("chain select did not go low with its count");

  property p_isolate;
    @(posedge mclk) disable iff (sys_rst)
      isOp(OP_ISOLATE_ROUTING) |=> !routingIsolateN;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("isolate code did not isolate routing");

  property p_restore;
    @(posedge mclk) disable iff (sys_rst)
      $rose(flopRestorePulse) |=> !flopRestorePulse;
  endproperty
  a_restore: assert property (p_restore)
    else $error("flop restore pulse longer than one cycle");

  property p_drop;
    @(posedge mclk) disable iff (sys_rst)
      isOp(OP_DROP_ALIGNMENT) && !syncFound |=>
        !wordAligned ##1 (!wordAligned || $past(syncFound));
  endproperty
  a_drop: assert property (p_drop)
    else $error("alignment not dropped");

  property p_cipher;
    @(posedge mclk) disable iff (sys_rst)
      $past(cipherOn) |-> cipherOn && securityLevel != SEC_OPEN;
  endproperty
  a_cipher: assert property (p_cipher)
    else $error("cipher bit cleared or level left open");

  property p_qual;
    @(posedge mclk) disable iff (sys_rst)
      accept && wrAddr == ADDR_CTL && qual_ff == '0 && !softBoot |=>
        $stable(ctl_ff);
  endproperty
  a_qual: assert property (p_qual)
    else $error("unqualified control bits changed");

  property p_undef;
    @(posedge mclk) disable iff (sys_rst)
      exec && cmd_ff == 5'h1F |=> $stable(routingIsolateN) &&
        $stable(wrDir_ff) && !rebootPulse && !flopRestorePulse;
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined code changed global signals");
endmodule

//--- dv/ccc_chain_rx.sv
// Downstream chain receiver model: rebuilds words from the serial pin.
// Assumes bits arrive most significant first while the valid flag is high.
module ccc_chain_rx
  import ccc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bitIn,
  input wire logic bitValid,
  output ccc_word_t word,
  output logic [7:0] nWords
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] nBit_ff;
  ccc_word_t shift_ff;

  // Counts only valid bits, so gaps between words never shift junk in
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nBit_ff <= 4'h0;
      shift_ff <= 16'h0000;
      word <= 16'h0000;
      nWords <= 8'h00;
    end else if (bitValid) begin
      nBit_ff <= nBit_ff + 4'h1;
      shift_ff <= {shift_ff[14:0], bitIn};
      if (nBit_ff == 4'hF) begin
        word <= {shift_ff[14:0], bitIn};
        nWords <= nWords + 8'h01;
      end
    end
  end
endmodule

//--- dv/config_command_control_bench.sv
// Bench for the command control block: register writes, reads, chain pins.
// Assumes a downstream receiver model on the serial chain output.
module config_command_control_bench
  import ccc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic syncFound = 1'b0;
  ccc_addr_t wrAddr = 6'h00;
  ccc_addr_t rdAddr = 6'h00;
  ccc_word_t wrData = 16'h0000;
  logic wrReady, rdValid, routingIsolateN, fuseKeySelect, idError;
  logic chainSelN, chainData, chainDataValid;
  ccc_word_t rdData, rxWord;
  ccc_sec_t securityLevel;
  logic [127:0] initVector;
  logic [7:0] rxCount;
  logic frameWrStb, multiFramePulse, startupPulse, chkClearPulse;
  logic flopRestorePulse, shutdownPulse, deviceOff, wordAligned;
  logic rebootPulse, cipherOn, initErrLow;
  ccc_word_t frameWrData, rebootAddr;
  logic [31:0] framePtr;
  localparam logic [31:0] CHK_GOOD = 32'hCAFE_F00D;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  initial forever #2.5 mclk = ~mclk;

  ccc_cfg_ctrl dut (.mclk, .sys_rst, .wrStb, .wrAddr, .wrData, .wrReady,
    .rdStb, .rdAddr, .viaInternalPort(1'b0), .rdData, .rdValid, .syncFound,
    .softRebootIn(1'b0), .chkRunning(CHK_GOOD),
    .frameRdData(16'h0000), .internalPortReq(1'b0), .frameWrStb,
    .frameWrData, .frameRdReq(), .framePtr, .multiFramePulse,
    .routingIsolateN, .startupPulse, .chkClearPulse,
    .flopRestorePulse, .shutdownPulse, .deviceOff, .wordAligned,
    .rebootPulse, .rebootAddr, .cipherOn, .securityLevel,
    .keepLink(), .fuseKeySelect, .internalPortEn(), .initErrLow,
    .idError, .chainSelN, .chainData, .chainDataValid, .initVector);

  ccc_chain_rx rx (.mclk, .sys_rst, .bitIn(chainData),
    .bitValid(chainDataValid), .word(rxWord), .nWords(rxCount));

  task automatic chk(input ccc_word_t got, input ccc_word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Strobe is held until an edge sees wrReady high
  task automatic wr(input ccc_addr_t a, input ccc_word_t d);
    @(posedge mclk);
    wrStb <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    do @(negedge mclk); while (wrReady !== 1'b1);
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input ccc_addr_t a, input ccc_word_t exp);
    @(posedge mclk);
    rdStb <= 1'b1;
    rdAddr <= a;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    chk({15'h0000, rdValid}, 16'h0001);
    chk(rdData, exp);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_CTL, CTL_RESET);
    rd(ADDR_QUAL, QUAL_RESET);
    rd(6'h3F, 16'h0000);
    $display("test reset done");
    @(posedge mclk);
    syncFound <= 1'b1;
    @(posedge mclk);
    syncFound <= 1'b0;
    wr(ADDR_QUAL, 16'h0004);
    wr(ADDR_CTL, 16'hFFFF);
    rd(ADDR_CTL, 16'h0005);
    chk({15'h0000, fuseKeySelect}, 16'h0001);
    chk({14'h0000, securityLevel}, 16'h0000);
    $display("test masked control done");
    wr(ADDR_FRAME_WR, 16'h1111);
    repeat (2) @(negedge mclk);
    chk({15'h0000, idError}, 16'h0001);
    rd(ADDR_PART_ID, 16'h1234);
    rd(ADDR_PART_ID, 16'h5678);
    $display("test identifier done");
    wr(ADDR_CMD, {11'h000, OP_ISOLATE_ROUTING});
    wr(ADDR_PTR_MAJ, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({15'h0000, routingIsolateN}, 16'h0000);
    wr(ADDR_CMD, 16'h001F);
    wr(ADDR_PTR_MIN, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({15'h0000, routingIsolateN}, 16'h0000);
    wr(ADDR_CMD, {11'h000, OP_FINAL_FRAME});
    wr(ADDR_PTR_MIN, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({15'h0000, routingIsolateN}, 16'h0001);
    $display("test commands done");
    wr(ADDR_CHAIN_SEL, 16'h0002);
    repeat (2) @(negedge mclk);
    chk({15'h0000, chainSelN}, 16'h0000);
    wr(ADDR_SER_OUT, 16'h0F0F);
    wr(ADDR_SER_OUT, 16'h0F0F);
    repeat (2) @(negedge mclk);
    chk({15'h0000, chainSelN}, 16'h0001);
    chk({8'h00, rxCount}, 16'h0000);
    // Back-to-back words fill the buffer while one is still shifting
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SER_OUT, {i[3:0], 12'h0A5});
    end
    repeat (90) @(negedge mclk);
    chk({8'h00, rxCount}, 16'h0004);
    chk(rxWord, 16'h30A5);
    $display("test chain done");
    wr(ADDR_INIT_VEC, 16'hBEEF);
    repeat (2) @(negedge mclk);
    chk(initVector[15:0], 16'hBEEF);
    $display("test init vector done");
    wr(ADDR_QUAL, 16'h0000);
    wr(ADDR_CTL, 16'hFFFF);
    rd(ADDR_CTL, 16'h0005);
    wr(ADDR_QUAL, 16'h0070);
    wr(ADDR_CTL, 16'h0040);
    wr(ADDR_CTL, 16'h0000);
    rd(ADDR_CTL, 16'h0055);
    chk({13'h0000, cipherOn, securityLevel}, 16'h0005);
    wr(ADDR_GEN_ADDR, 16'h0123);
    wr(ADDR_CMD, {11'h000, OP_WARM_REBOOT});
    wr(ADDR_PTR_MIN, 16'h0007);
    @(negedge mclk);
    chk({15'h0000, rebootPulse}, 16'h0001);
    chk(rebootAddr, 16'h0123);
    chk(framePtr[15:0], 16'h0007);
    rd(ADDR_QUAL, QUAL_RESET);
    rd(ADDR_CTL, 16'h0055);
    $display("test control lock done");
    wr(ADDR_PART_ID, 16'h1234);
    wr(ADDR_PART_ID, 16'h5678);
    wr(ADDR_CMD, {11'h000, OP_WRITE_FRAMES});
    wr(ADDR_PTR_MIN, 16'h0000);
    wr(ADDR_FRAME_WR, 16'h2222);
    @(negedge mclk);
    chk({15'h0000, frameWrStb}, 16'h0001);
    chk(frameWrData, 16'h2222);
    wr(ADDR_CMD, {11'h000, OP_MULTI_FRAME});
    wr(ADDR_PTR_MIN, 16'h0000);
    @(negedge mclk);
    chk({15'h0000, multiFramePulse}, 16'h0001);
    wr(ADDR_CMD, {11'h000, OP_FLOP_RESTORE});
    wr(ADDR_PTR_MIN, 16'h0000);
    @(negedge mclk);
    chk({15'h0000, flopRestorePulse}, 16'h0001);
    @(negedge mclk);
    chk({15'h0000, flopRestorePulse}, 16'h0000);
    $display("test frames done");
    wr(ADDR_CMD, {11'h000, OP_SHUTDOWN});
    wr(ADDR_PTR_MIN, 16'h0000);
    wr(ADDR_CMD, {11'h000, OP_CHECK_CLEAR});
    wr(ADDR_PTR_MIN, 16'h0000);
    @(negedge mclk);
    chk({14'h0000, shutdownPulse, chkClearPulse}, 16'h0003);
    chk({15'h0000, deviceOff}, 16'h0001);
    wr(ADDR_CHECK, 16'h0000);
    wr(ADDR_CHECK, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({15'h0000, initErrLow}, 16'h0001);
    wr(ADDR_CMD, {11'h000, OP_START});
    wr(ADDR_PTR_MIN, 16'h0000);
    wr(ADDR_CHECK, CHK_GOOD[31:16]);
    wr(ADDR_CHECK, CHK_GOOD[15:0]);
    wr(ADDR_CMD, {11'h000, OP_DROP_ALIGNMENT});
    wr(ADDR_PTR_MIN, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({13'h0000, startupPulse, wordAligned, initErrLow}, 16'h0004);
    $display("test sequences done");
    give_verdict();
  end
endmodule
